// file: src/opc_phy_ctrl.sv
// Behaviour
// - Writing ones to a set address sets those bits, others unchanged.
// - Writing ones to a clear address clears those bits, others unchanged.
// - Set and clear addresses read the same contents, no side effect.
// - Read-only maker code, low byte at address zero, high byte next.
// - Read-only part code, low byte at address two, high at three.
// - First control bit zero selects low speed (0) or full speed (1).
// - First control bit two selects pair inputs (0) or data plus zero (1).
// - With bit four set, SE0 attaches the D+ pull-up and raises a flag.
// - Bit five with suspend makes the interrupt pin an active-low output.
// - Bit six picks UART mode; bit seven remaps general pins to UART.
// - Second control bits zero to three switch the four line resistors.
// - Second control bit four grounds the ID pin.
// - Second control bit five powers VBUS from the charge pump.
// - Second control bit six discharges VBUS through a resistor.
// - All control bits are zero after reset.
//
// Top of the transceiver control block: two-wire serial slave plus pin controls.
// Assumes scl and sda arrive asynchronously and are much slower than mclk;
// the board resolves sda from sda_oe (driven low while sda_oe is high).
`timescale 1ns/10ps
module opc_phy_ctrl
    import opc_pkg::*;
#(
    parameter logic [6:0]  DEV_ADDR   = DEV_ADDR_DEF,
    parameter logic [15:0] MAKER_CODE = MAKER_DEF,
    parameter logic [15:0] PART_CODE  = PART_DEF
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic se0_in,
    input  wire logic irq_req,
    output logic      oe_int_n_out,
    output logic      oe_int_oe,
    output logic      acon_flag,
    output logic      line_speed_full,
    output logic      low_power,
    output logic      line_encoding_select,
    output logic      uart_mode,
    output logic      gpio0_uart_rx,
    output logic      gpio1_uart_tx,
    output logic      dplus_pullup,
    output logic      dminus_pullup,
    output logic      dplus_pulldown,
    output logic      dminus_pulldown,
    output logic      id_pin_ground_drive,
    output logic      vbus_pump_drive,
    output logic      vbus_discharge
);
    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [2:0] se0_s;
        logic       scl_f;
        logic       sda_f;
        logic       se0_f;
        opc_state_e st;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic       rw;
        logic       nack;
        logic       wr_stb;
        logic       acon_set;
        logic       sda_oe;
        logic       sda_out;
        logic       acon_flag;
        logic       oe_int_oe;
        logic       oe_int_n;
        logic [7:0] c1_out;
        logic [6:0] c2_out;
    } opc_top_s;

    opc_top_s q, d;
    opc_reg_if rif ();

    opc_reg_bank #(
        .MAKER_CODE (MAKER_CODE),
        .PART_CODE  (PART_CODE)
    ) u_bank (
        .mclk  (mclk),
        .rst_n (rst_n),
        .rif   (rif)
    );

    logic scl_n;
    logic sda_n;
    logic se0_n;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    always_comb begin
        // A level counts only once the second and third stages agree
        scl_n = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[2] : q.scl_f;
        sda_n = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_f;
        se0_n = (q.se0_s[1] == q.se0_s[2]) ? q.se0_s[2] : q.se0_f;
        scl_rise = !q.scl_f && scl_n;
        scl_fall = q.scl_f && !scl_n;
        start_ev = q.scl_f && scl_n && q.sda_f && !sda_n;
        stop_ev  = q.scl_f && scl_n && !q.sda_f && sda_n;
    end

    always_comb begin
        d = q;
        d.scl_s = {q.scl_s[1:0], scl_in};
        d.sda_s = {q.sda_s[1:0], sda_in};
        d.se0_s = {q.se0_s[1:0], se0_in};
        d.scl_f = scl_n;
        d.sda_f = sda_n;
        d.se0_f = se0_n;
        d.wr_stb   = 1'b0;
        d.acon_set = 1'b0;
        d.sda_out  = 1'b0;

        // Byte-wide access over the two-wire bus
        if (start_ev) begin
            d.st     = ST_ADDR;
            d.cnt    = 4'h0;
            d.sda_oe = 1'b0;
        end else if (stop_ev) begin
            d.st     = ST_IDLE;
            d.sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (q.st)
                ST_ADDR,
                ST_REG,
                ST_WDATA: begin
                    d.shift = {q.shift[6:0], sda_n};
                    d.cnt   = 4'(q.cnt + 4'h1);
                end
                ST_MACK: d.nack = sda_n;
                default: d.nack = q.nack;
            endcase
        end else if (scl_fall) begin
            case (q.st)
                ST_ADDR: begin
                    if (q.cnt == BITS_BYTE) begin
                        if (q.shift[7:1] == DEV_ADDR) begin
                            d.rw     = q.shift[0];
                            d.sda_oe = 1'b1;
                            d.st     = ST_AACK;
                        end else begin
                            // Not ours: stay off the bus until the next start
                            d.st = ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    d.cnt = 4'h0;
                    if (q.rw) begin
                        d.shift  = rif.rdata;
                        d.sda_oe = !rif.rdata[7];
                        d.ptr    = 8'(q.ptr + 8'h01);
                        d.st     = ST_RDATA;
                    end else begin
                        d.sda_oe = 1'b0;
                        d.st     = ST_REG;
                    end
                end
                ST_REG: begin
                    if (q.cnt == BITS_BYTE) begin
                        d.ptr    = q.shift;
                        d.sda_oe = 1'b1;
                        d.st     = ST_RACKW;
                    end
                end
                ST_RACKW: begin
                    d.sda_oe = 1'b0;
                    d.cnt    = 4'h0;
                    d.st     = ST_WDATA;
                end
                ST_WDATA: begin
                    if (q.cnt == BITS_BYTE) begin
                        d.wr_stb = 1'b1;
                        d.sda_oe = 1'b1;
                        d.st     = ST_WACK;
                    end
                end
                ST_WACK: begin
                    // Pointer moves only after the bank has taken the byte
                    d.sda_oe = 1'b0;
                    d.ptr    = 8'(q.ptr + 8'h01);
                    d.cnt    = 4'h0;
                    d.st     = ST_WDATA;
                end
                ST_RDATA: begin
                    d.cnt = 4'(q.cnt + 4'h1);
                    if (q.cnt == BITS_LAST) begin
                        d.sda_oe = 1'b0;
                        d.st     = ST_MACK;
                    end else begin
                        d.shift  = {q.shift[6:0], 1'b0};
                        d.sda_oe = !q.shift[6];
                    end
                end
                ST_MACK: begin
                    if (q.nack) begin
                        d.st = ST_IDLE;
                    end else begin
                        // Reads only move the pointer, never the registers
                        d.shift  = rif.rdata;
                        d.sda_oe = !rif.rdata[7];
                        d.ptr    = 8'(q.ptr + 8'h01);
                        d.cnt    = 4'h0;
                        d.st     = ST_RDATA;
                    end
                end
                default: d.st = ST_IDLE;
            endcase
        end

        // Disconnect attach on a fresh SE0 while enabled
        if (!q.se0_f && se0_n && rif.ctrl1[B_ACON_EN]) begin
            d.acon_set  = 1'b1;
            d.acon_flag = 1'b1;
        end else if (!rif.ctrl1[B_ACON_EN]) begin
            d.acon_flag = 1'b0;
        end

        // Pin only turns output in suspend; in full power the SIE owns it
        d.oe_int_oe = rif.ctrl1[B_OEINT] && rif.ctrl1[B_SUSPEND];
        d.oe_int_n  = !(irq_req || q.acon_flag);
        d.c1_out    = rif.ctrl1;
        d.c2_out    = rif.ctrl2[B_VBDIS:B_DPPU];
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q          <= '0;
            q.scl_s    <= 3'h7;
            q.sda_s    <= 3'h7;
            q.scl_f    <= 1'b1;
            q.sda_f    <= 1'b1;
            q.st       <= ST_IDLE;
            q.oe_int_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign rif.wr_stb   = q.wr_stb;
    assign rif.addr     = q.ptr;
    assign rif.wdata    = q.shift;
    assign rif.acon_set = q.acon_set;

    assign sda_out              = q.sda_out;
    assign sda_oe               = q.sda_oe;
    assign oe_int_n_out         = q.oe_int_n;
    assign oe_int_oe            = q.oe_int_oe;
    assign acon_flag            = q.acon_flag;
    assign line_speed_full      = q.c1_out[B_SPEED];
    assign low_power            = q.c1_out[B_SUSPEND];
    assign line_encoding_select = q.c1_out[B_ENCODE];
    assign uart_mode            = q.c1_out[B_UART];
    assign gpio0_uart_rx        = q.c1_out[B_UART_IO];
    assign gpio1_uart_tx        = q.c1_out[B_UART_IO];
    assign dplus_pullup         = q.c2_out[B_DPPU];
    assign dminus_pullup        = q.c2_out[B_DMPU];
    assign dplus_pulldown       = q.c2_out[B_DPPD];
    assign dminus_pulldown      = q.c2_out[B_DMPD];
    assign id_pin_ground_drive  = q.c2_out[B_IDGND];
    assign vbus_pump_drive      = q.c2_out[B_VBDRV];
    assign vbus_discharge       = q.c2_out[B_VBDIS];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_read_quiet;
        !rif.wr_stb && !rif.acon_set |=> $stable(rif.ctrl1) && $stable(rif.ctrl2);
    endproperty
    a_read_quiet: assert property (p_read_quiet)
        else $error("register changed without a write");

    // Pin outputs are one register stage behind the bank
    property p_speed_enc;
        1 |=> line_speed_full == $past(rif.ctrl1[B_SPEED])
              && line_encoding_select == $past(rif.ctrl1[B_ENCODE]);
    endproperty
    a_speed_enc: assert property (p_speed_enc)
        else $error("speed or encoding output wrong");

    property p_acon;
        !q.se0_f && se0_n && rif.ctrl1[B_ACON_EN] |-> ##[2:3] dplus_pullup && acon_flag;
    endproperty
    a_acon: assert property (p_acon)
        else $error("SE0 did not attach D+ pull-up");

    property p_flag_clear;
        !rif.ctrl1[B_ACON_EN] |=> !acon_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("attach flag stayed with attach disabled");

    property p_int_pin;
        1 |=> oe_int_oe == ($past(rif.ctrl1[B_OEINT]) && $past(rif.ctrl1[B_SUSPEND]));
    endproperty
    a_int_pin: assert property (p_int_pin)
        else $error("interrupt pin direction wrong");

    property p_int_low;
        1 |=> oe_int_n_out == !($past(irq_req) || $past(acon_flag));
    endproperty
    a_int_low: assert property (p_int_low)
        else $error("interrupt pin level wrong");

    property p_uart;
        1 |=> uart_mode == $past(rif.ctrl1[B_UART])
              && gpio0_uart_rx == $past(rif.ctrl1[B_UART_IO]);
    endproperty
    a_uart: assert property (p_uart)
        else $error("uart mode or remap wrong");

    property p_line_ctl;
        1 |=> {vbus_discharge, vbus_pump_drive, id_pin_ground_drive, dminus_pulldown,
               dplus_pulldown, dminus_pullup, dplus_pullup} == $past(rif.ctrl2[B_VBDIS:B_DPPU]);
    endproperty
    a_line_ctl: assert property (p_line_ctl)
        else $error("line control outputs wrong");

    property p_addr_ack;
        q.st == ST_ADDR && scl_fall && q.cnt == BITS_BYTE && q.shift[7:1] == DEV_ADDR
            && !start_ev && !stop_ev |=> sda_oe && q.st == ST_AACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("own address not acknowledged");

    property p_foreign;
        q.st == ST_ADDR && scl_fall && q.cnt == BITS_BYTE && q.shift[7:1] != DEV_ADDR
            && !start_ev && !stop_ev |=> !sda_oe && q.st == ST_IDLE;
    endproperty
    a_foreign: assert property (p_foreign)
        else $error("foreign address not ignored");

    property p_stop_idle;
        stop_ev |=> q.st == ST_IDLE && !sda_oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("stop did not release the bus");

    property p_ptr_set;
        q.st == ST_REG && scl_fall && q.cnt == BITS_BYTE |=> rif.addr == $past(q.shift) && sda_oe;
    endproperty
    a_ptr_set: assert property (p_ptr_set)
        else $error("register pointer not loaded");

    property p_wr_commit;
        q.st == ST_WDATA && scl_fall && q.cnt == BITS_BYTE
            |=> rif.wr_stb && rif.wdata == $past(q.shift);
    endproperty
    a_wr_commit: assert property (p_wr_commit)
        else $error("data byte not committed");

    property p_rd_first;
        q.st == ST_AACK && scl_fall && q.rw
            |=> q.st == ST_RDATA && sda_oe == !$past(rif.rdata[7]);
    endproperty
    a_rd_first: assert property (p_rd_first)
        else $error("first read bit not driven");
endmodule

// file: src/opc_pkg.sv
// Constants shared by the control register bank and its serial front end.
// Assumes byte-wide registers addressed by an eight-bit register pointer.
package opc_pkg;
    // Register addresses
    localparam logic [7:0] A_MAKER_LO = 8'h00;
    localparam logic [7:0] A_MAKER_HI = 8'h01;
    localparam logic [7:0] A_PART_LO  = 8'h02;
    localparam logic [7:0] A_PART_HI  = 8'h03;
    localparam logic [7:0] A_C1_SET   = 8'h04;
    localparam logic [7:0] A_C1_CLR   = 8'h05;
    localparam logic [7:0] A_C2_SET   = 8'h06;
    localparam logic [7:0] A_C2_CLR   = 8'h07;
    // First control register fields
    localparam int B_SPEED   = 0;
    localparam int B_SUSPEND = 1;
    localparam int B_ENCODE  = 2;
    localparam int B_ACON_EN = 4;
    localparam int B_OEINT   = 5;
    localparam int B_UART    = 6;
    localparam int B_UART_IO = 7;
    // Second control register fields
    localparam int B_DPPU    = 0;
    localparam int B_DMPU    = 1;
    localparam int B_DPPD    = 2;
    localparam int B_DMPD    = 3;
    localparam int B_IDGND   = 4;
    localparam int B_VBDRV   = 5;
    localparam int B_VBDIS   = 6;
    // Reset values
    localparam logic [7:0] C1_RESET  = 8'h00;
    localparam logic [7:0] C2_RESET  = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Serial bus constants
    localparam logic [6:0] DEV_ADDR_DEF = 7'h2D;
    localparam logic [3:0] BITS_BYTE    = 4'h8;
    localparam logic [3:0] BITS_LAST    = 4'h7;
    // Identification words, values arbitrary
    localparam logic [15:0] MAKER_DEF = 16'hA55A;
    localparam logic [15:0] PART_DEF  = 16'h0C3E;

    typedef enum logic [8:0] {
        ST_IDLE  = 9'h001,
        ST_ADDR  = 9'h002,
        ST_AACK  = 9'h004,
        ST_REG   = 9'h008,
        ST_RACKW = 9'h010,
        ST_WDATA = 9'h020,
        ST_WACK  = 9'h040,
        ST_RDATA = 9'h080,
        ST_MACK  = 9'h100
    } opc_state_e;
endpackage

// file: src/opc_reg_if.sv
// Internal carrier between the serial front end and the register bank.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface opc_reg_if;
    logic       wr_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       acon_set;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    modport front (output wr_stb, output addr, output wdata, output acon_set,
                   input rdata, input ctrl1, input ctrl2);
    modport bank  (input wr_stb, input addr, input wdata, input acon_set,
                   output rdata, output ctrl1, output ctrl2);
endinterface

// file: src/opc_reg_bank.sv
// Byte-wide register bank: identification words and two set/clear control registers.
// Assumes one write strobe per byte and a pointer held stable while read data settle.
`timescale 1ns/10ps
module opc_reg_bank
    import opc_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE = MAKER_DEF,
    parameter logic [15:0] PART_CODE  = PART_DEF
) (
    input wire logic mclk,
    input wire logic rst_n,
    opc_reg_if.bank  rif
);
    typedef struct packed {
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] rdata;
    } opc_bank_s;

    opc_bank_s q, d;

    always_comb begin
        d = q;
        if (rif.wr_stb) begin
            case (rif.addr)
                A_C1_SET: d.ctrl1 = q.ctrl1 | rif.wdata;
                A_C1_CLR: d.ctrl1 = q.ctrl1 & ~rif.wdata;
                A_C2_SET: d.ctrl2 = q.ctrl2 | rif.wdata;
                A_C2_CLR: d.ctrl2 = q.ctrl2 & ~rif.wdata;
                default:  d = q;
            endcase
        end
        // Hardware attach applied after the clear so it wins a same-cycle clear
        if (rif.acon_set) begin
            d.ctrl2[B_DPPU] = 1'b1;
        end
        // Both addresses of a set/clear pair read the same contents
        case (rif.addr)
            A_MAKER_LO: d.rdata = MAKER_CODE[7:0];
            A_MAKER_HI: d.rdata = MAKER_CODE[15:8];
            A_PART_LO:  d.rdata = PART_CODE[7:0];
            A_PART_HI:  d.rdata = PART_CODE[15:8];
            A_C1_SET,
            A_C1_CLR:   d.rdata = q.ctrl1;
            A_C2_SET,
            A_C2_CLR:   d.rdata = q.ctrl2;
            default:    d.rdata = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q <= {C1_RESET, C2_RESET, BYTE_ZERO};
        end else begin
            q <= d;
        end
    end

    assign rif.ctrl1 = q.ctrl1;
    assign rif.ctrl2 = q.ctrl2;
    assign rif.rdata = q.rdata;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_set_one;
        rif.wr_stb && rif.addr == A_C1_SET |=> rif.ctrl1 == ($past(rif.ctrl1) | $past(rif.wdata));
    endproperty
    a_set_one: assert property (p_set_one)
        else $error("set write did not OR bits in");

    property p_clr_one;
        rif.wr_stb && rif.addr == A_C1_CLR |=> rif.ctrl1 == ($past(rif.ctrl1) & ~$past(rif.wdata));
    endproperty
    a_clr_one: assert property (p_clr_one)
        else $error("clear write did not clear bits");

    property p_maker_hi;
        rif.addr == A_MAKER_HI |=> rif.rdata == MAKER_CODE[15:8];
    endproperty
    a_maker_hi: assert property (p_maker_hi)
        else $error("maker code upper byte wrong");

    property p_part_lo;
        rif.addr == A_PART_LO |=> rif.rdata == PART_CODE[7:0];
    endproperty
    a_part_lo: assert property (p_part_lo)
        else $error("part code lower byte wrong");

    property p_reset_zero;
        $rose(rst_n) |-> rif.ctrl1 == C1_RESET && rif.ctrl2 == C2_RESET;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("control registers not reset");
endmodule

// file: verification/opc_host_model.sv
// Host controller model: byte register reads and writes on the two-wire control bus.
// Assumes the bench resolves sda_line from sda_m and the device's pull-down enable.
`timescale 1ns/10ps
module opc_host_model
    import opc_pkg::*;
(
    input  wire logic mclk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_m
);
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end
    // Half bit of eight clocks, well above the device's synchroniser delay, so its synchronisers always catch up
    task automatic hp();
        repeat (8) @(negedge mclk);
    endtask
    // Also serves as repeated start after an acknowledge bit
    task automatic start();
        sda_m = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        sda_m = 1'b0;
        hp();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_m = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        sda_m = 1'b1;
        hp();
    endtask
    task automatic bit_io(input logic b, output logic s);
        sda_m = b;
        hp();
        scl = 1'b1;
        hp();
        s   = sda_line;
        scl = 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(last, s);
    endtask
    task automatic reg_write(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                             output logic ok);
        logic k0, k1, k2;
        start();
        put_byte({dev, 1'b0}, k0);
        put_byte(a, k1);
        put_byte(d, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        logic k;
        start();
        put_byte({DEV_ADDR_DEF, 1'b0}, k);
        put_byte(a, k);
        start();
        put_byte({DEV_ADDR_DEF, 1'b1}, k);
        get_byte(1'b1, d);
        stop();
    endtask
    // Four-byte burst: master acknowledges all but the last byte, first byte lands on top
    task automatic reg_read4(input logic [7:0] a, output logic [31:0] w);
        logic k;
        start();
        put_byte({DEV_ADDR_DEF, 1'b0}, k);
        put_byte(a, k);
        start();
        put_byte({DEV_ADDR_DEF, 1'b1}, k);
        for (int i = 3; i >= 0; i--) get_byte(i == 0, w[8*i +: 8]);
        stop();
    endtask
endmodule

// file: verification/opc_phy_ctrl_tb_top.sv
// Self-checking bench for the transceiver control block, driven through the host model.
// Assumes a pulled-up data line; the bench plays the SE0 detector and interrupt source.
`timescale 1ns/10ps
module opc_phy_ctrl_tb_top
    import opc_pkg::*;
;
    logic       mclk, rst_n, se0_in, irq_req, scl, sda_m, ok;
    logic       sda_out, sda_oe, oe_int_n_out, oe_int_oe, acon_flag;
    logic [7:0] c1, c2, rd;
    logic [31:0] rw4;
    wire  [5:0] o1;
    wire  [6:0] o2;
    int         bad_count, comparisons;
    wire        sda_line = sda_m & !sda_oe;
    logic [7:0] ids [4] = '{MAKER_DEF[7:0], MAKER_DEF[15:8], PART_DEF[7:0], PART_DEF[15:8]};
    logic [15:0] wtab [10] = '{16'h04A5, 16'h045A, 16'h050F, 16'h0500, 16'h067F,
                               16'h072A, 16'h0755, 16'h00FF, 16'h09FF, 16'h05FF};

    opc_phy_ctrl uut (
        .mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .se0_in(se0_in), .irq_req(irq_req),
        .oe_int_n_out(oe_int_n_out), .oe_int_oe(oe_int_oe), .acon_flag(acon_flag),
        .line_speed_full(o1[0]), .low_power(o1[1]), .line_encoding_select(o1[2]),
        .uart_mode(o1[3]), .gpio0_uart_rx(o1[4]), .gpio1_uart_tx(o1[5]),
        .dplus_pullup(o2[0]), .dminus_pullup(o2[1]), .dplus_pulldown(o2[2]),
        .dminus_pulldown(o2[3]), .id_pin_ground_drive(o2[4]), .vbus_pump_drive(o2[5]),
        .vbus_discharge(o2[6])
    );
    opc_host_model host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Pins and both readable addresses of each control register against the model
    task automatic verify();
        logic [7:0] e1;
        repeat (4) @(negedge mclk);
        e1 = {2'b00, {2{c1[7]}}, c1[6], c1[2:0]};
        check("ctrl1 pins", {2'b00, o1}, e1);
        check("ctrl2 pins", {1'b0, o2}, {1'b0, c2[6:0]});
        check("int pin dir", {7'h00, oe_int_oe}, {7'h00, c1[5] & c1[1]});
        for (int i = 4; i < 8; i++) begin
            host.reg_read(i[7:0], rd);
            check("ctrl read", rd, (i < 6) ? c1 : c2);
        end
    endtask
    task automatic wr_chk(input logic [7:0] a, input logic [7:0] d);
        host.reg_write(DEV_ADDR_DEF, a, d, ok);
        check("write ack", {7'h00, ok}, 8'h01);
        case (a)
            A_C1_SET: c1 = c1 | d;
            A_C1_CLR: c1 = c1 & ~d;
            A_C2_SET: c2 = c2 | d;
            A_C2_CLR: c2 = c2 & ~d;
            default: ;
        endcase
        verify();
    endtask
    task automatic se0_pulse();
        se0_in = 1'b1;
        repeat (8) @(negedge mclk);
        se0_in = 1'b0;
        repeat (4) @(negedge mclk);
    endtask
    // Called at the falling edge that releases reset; model registers already zeroed
    task automatic after_reset();
        check("rst pins", {4'h0, sda_out, sda_oe, oe_int_n_out, acon_flag}, 8'h02);
        verify();
    endtask

    initial begin
        // Tests need about 70k cycles; this stops a hang near 90k
        #900_000;
        bad_count++;
        results();
    end

    initial begin
        rst_n = 1'b0;
        se0_in = 1'b0;
        irq_req = 1'b0;
        c1 = 8'h00;
        c2 = 8'h00;
        bad_count = 0;
        comparisons = 0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        after_reset();
        $display("test reset done");
        for (int i = 0; i < 10; i++) wr_chk(wtab[i][15:8], wtab[i][7:0]);
        for (int i = 0; i < 4; i++) begin
            host.reg_read(i[7:0], rd);
            check("id byte", rd, ids[i]);
        end
        host.reg_read4(A_MAKER_LO, rw4);
        for (int i = 0; i < 4; i++) check("burst", rw4[31-8*i -: 8], ids[i]);
        host.reg_read(8'h09, rd);
        check("unmapped read", rd, 8'h00);
        $display("test set clear and ids done");
        host.reg_write(7'h2C, A_C2_SET, 8'h7F, ok);
        check("foreign address ack", {7'h00, ok}, 8'h00);
        verify();
        $display("test foreign address done");
        wr_chk(A_C1_SET, 8'h22);
        irq_req = 1'b1;
        repeat (4) @(negedge mclk);
        check("int pin low", {7'h00, oe_int_n_out}, 8'h00);
        irq_req = 1'b0;
        repeat (4) @(negedge mclk);
        check("int pin idle", {7'h00, oe_int_n_out}, 8'h01);
        wr_chk(A_C1_CLR, 8'h02);
        $display("test interrupt pin done");
        se0_pulse();
        check("no attach flag", {7'h00, acon_flag}, 8'h00);
        verify();
        wr_chk(A_C1_SET, 8'h12);
        se0_pulse();
        c2[0] = 1'b1;
        check("attach flag", {7'h00, acon_flag}, 8'h01);
        check("attach int pin", {6'h00, oe_int_oe, oe_int_n_out}, 8'h02);
        verify();
        wr_chk(A_C1_CLR, 8'h32);
        check("flag cleared", {7'h00, acon_flag}, 8'h00);
        wr_chk(A_C2_CLR, 8'h01);
        $display("test disconnect attach done");
        wr_chk(A_C1_SET, 8'h41);
        wr_chk(A_C2_SET, 8'h3C);
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        c1 = 8'h00;
        c2 = 8'h00;
        after_reset();
        $display("test mid-run reset done");
        results();
    end
endmodule
